// ---- slp_map.svh ----
// constants for the seven-level priority interrupt unit
`ifndef SLP_MAP_SVH
`define SLP_MAP_SVH

// device code of the interrupt system on the in-out bus (octal 004)
`define SLP_DEV_CODE    9'h004
// unrelocated interrupt location bases (octal 40 and 140)
`define SLP_BASE_FIRST  8'h20
`define SLP_BASE_SECOND 8'h60

// conditions-out word bit positions (index 0 is the rightmost bit)
`define SLP_CO_CLEAR    12
`define SLP_CO_FORCE    11
`define SLP_CO_TURN_ON  10
`define SLP_CO_TURN_OFF 9
`define SLP_CO_DEACT    8
`define SLP_CO_ACT      7
`define SLP_CO_SEL_TOP  7

// conditions-in word layout
`define SLP_CI_HELD_TOP 15
`define SLP_CI_SYS_ON   7
`define SLP_CI_ON_TOP   7

// reset values
`define SLP_LVL_RST     7'h00
`define SLP_STAT_RST    18'h00000
`define SLP_ADDR_RST    8'h00
`define SLP_LVLNUM_RST  3'h0

`endif

// ---- slp_pkg.sv ----
// types shared by the priority interrupt unit modules
package slp_pkg;

  typedef enum logic [3:0] {
    SLP_IDLE   = 4'h1,
    SLP_FIRST  = 4'h2,
    SLP_SECOND = 4'h4,
    SLP_HUNG   = 4'h8
  } slp_fsm_type;

  // class of the instruction just run from an interrupt location
  typedef enum logic [2:0] {
    SLP_CLS_NONIO      = 3'h0,
    SLP_CLS_NONIO_JUMP = 3'h1,
    SLP_CLS_DATA_IO    = 3'h2,
    SLP_CLS_BLOCK_MORE = 3'h3,
    SLP_CLS_BLOCK_DONE = 3'h4,
    SLP_CLS_COND_IO    = 3'h5
  } slp_class_type;

  typedef struct packed {
    slp_fsm_type fsm;
    logic        sys_on;
    logic [7:1]  level_on;
    logic [7:1]  accepted;
    logic [7:1]  held;
    logic [2:0]  cur_level;
    logic [7:0]  addr;
    logic        start_pulse;
    logic        exec_mode;
    logic        leave_user;
    logic        hang;
    logic [17:0] status;
  } slp_state_type;

endpackage

// ---- slp_cmd_if.sv ----
// decoded conditions-out command carried to the unit core
`timescale 1ns/100ps
`default_nettype none
interface slp_cmd_if;
  logic       clear_all;
  logic       force_req;
  logic       turn_on;
  logic       turn_off;
  logic       deact;
  logic       act;
  logic [7:1] sel;
  modport src (output clear_all, force_req, turn_on, turn_off, deact, act,
               sel);
  modport snk (input clear_all, force_req, turn_on, turn_off, deact, act,
               sel);
endinterface
`default_nettype wire

// ---- slp_cond_decode.sv ----
// conditions-out word decoder for the interrupt system
`timescale 1ns/100ps
`default_nettype none
`include "slp_map.svh"
module slp_cond_decode
  import slp_pkg::*;
(
  input  wire logic        strobe_in,
  input  wire logic [17:0] word_in,
  slp_cmd_if.src           cmd
);
  assign cmd.clear_all = strobe_in & word_in[`SLP_CO_CLEAR];
  assign cmd.force_req = strobe_in & word_in[`SLP_CO_FORCE];
  assign cmd.turn_on   = strobe_in & word_in[`SLP_CO_TURN_ON];
  assign cmd.turn_off  = strobe_in & word_in[`SLP_CO_TURN_OFF];
  assign cmd.deact     = strobe_in & word_in[`SLP_CO_DEACT];
  assign cmd.act       = strobe_in & word_in[`SLP_CO_ACT];

  // level 1 sits in the leftmost select bit
  genvar g;
  generate
    for (g = 1; g <= 7; g = g + 1) begin : g_sel
      assign cmd.sel[g] = word_in[`SLP_CO_SEL_TOP - g];
    end
  endgenerate
endmodule
`default_nettype wire

// ---- slp_prio_find.sv ----
// finds the highest-priority (lowest numbered) set level
`timescale 1ns/100ps
`default_nettype none
module slp_prio_find
  import slp_pkg::*;
(
  input  wire logic [7:1] vec_in,
  output logic            found_out,
  output logic [2:0]      level_out
);
  always_comb begin
    found_out = 1'b0;
    level_out = 3'h0;
    for (int i = 7; i >= 1; i--) begin
      if (vec_in[i]) begin
        found_out = 1'b1;
        level_out = 3'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ---- slp_unit.sv ----
// seven-level priority interrupt unit core
// Operation
// R1 - seven levels in a chain, level one highest, level seven lowest
// R2 - peripherals take their level from conditions bits; zero disconnects
// R3 - many peripherals may share one level; one may use two levels
// R4 - peripheral holds its request until software clears it
// R5 - peripheral flag requests only while its enable flag is set
// R6 - accept only on levels on, at memory access, unless starting or held
// R7 - system off still accepts; when on, highest accepted served first
// R8 - no start while a held level outranks every waiting level
// R9 - break in only after fetches or between block-transfer words
// R10 - program counter still points at interrupted instruction on start
// R11 - level N runs location 40+2N; 41+2N is its second location
// R12 - second processor uses 140+2N and 141+2N instead
// R13 - interrupt-location instructions always run in executive mode
// R14 - special handling only for hardware-driven fetches from the locations
// R15 - after non-IO interrupt instruction, hold level and resume at PC
// R16 - user mode plus call or jump type leaves user mode
// R17 - non-jump keeps interrupt held, interrupted program becomes routine
// R18 - incomplete block or single data transfer dismisses automatically
// R19 - block count done runs second location as non-IO instruction
// R20 - condition op first or IO op second location hangs the processor
// R21 - interrupt system answers condition ops at device code 004
// R22 - held level blocks starts on it and lower levels, not accepts
// R23 - dismiss-and-jump with system on clears highest held level
// R24 - reset turns system and levels off, clears accepted and held
`timescale 1ns/100ps
`default_nettype none
`include "slp_map.svh"
module slp_unit
  import slp_pkg::*;
#(
  parameter bit SECOND_CPU = 1'b0
)(
  input  wire logic          clock_in,
  input  wire logic          reset_n_in,
  input  wire logic          clk_en_in,
  input  wire logic [7:1]    request_in,
  input  wire logic          mem_access_in,
  input  wire logic          stop_point_in,
  input  wire logic          cond_out_in,
  input  wire logic [8:0]    device_in,
  input  wire logic [17:0]   cond_word_in,
  input  wire logic          instr_done_in,
  input  wire slp_class_type instr_class_in,
  input  wire logic          user_mode_in,
  input  wire logic          dismiss_in,
  output logic               intr_start_out,
  output logic [7:0]         intr_addr_out,
  output logic               exec_mode_out,
  output logic               leave_user_out,
  output logic               hang_out,
  output logic [7:1]         held_out,
  output logic [17:0]        status_out
);

  // R12 second processor base
  localparam logic [7:0] BASE = SECOND_CPU ? `SLP_BASE_SECOND
                                           : `SLP_BASE_FIRST;

  slp_state_type state_reg;
  slp_state_type state_next;

  logic       held_found;
  logic [2:0] held_level;
  logic [7:1] above_held;
  logic [7:1] candidates;
  logic       cand_found;
  logic [2:0] cand_level;
  logic       cmd_strobe;

  slp_cmd_if cmd ();

  // R21 device code decode
  assign cmd_strobe = cond_out_in && (device_in == `SLP_DEV_CODE);

  slp_cond_decode u_decode (
    .strobe_in (cmd_strobe),
    .word_in   (cond_word_in),
    .cmd       (cmd.src)
  );

  slp_prio_find u_held_find (
    .vec_in    (state_reg.held),
    .found_out (held_found),
    .level_out (held_level)
  );

  // R8 only levels above the highest held one may start
  always_comb begin
    above_held = 7'h00;
    for (int i = 1; i <= 7; i++) begin
      above_held[i] = !held_found || (3'(i) < held_level);
    end
  end

  // R22 lower levels still accept, they just cannot start
  assign candidates = state_reg.accepted & above_held;

  // R1 level one wins the chain
  slp_prio_find u_cand_find (
    .vec_in    (candidates),
    .found_out (cand_found),
    .level_out (cand_level)
  );

  function automatic logic [7:0] slot_addr(input logic [2:0] lvl);
    slot_addr = BASE + {4'h0, lvl, 1'b0};
  endfunction

  always_comb begin
    state_next             = state_reg;
    state_next.start_pulse = 1'b0;
    state_next.leave_user  = 1'b0;

    // R6 acceptance gate; requests from R4 lines stay until cleared
    if (mem_access_in && state_reg.fsm == SLP_IDLE) begin
      state_next.accepted = state_reg.accepted
                          | (request_in & state_reg.level_on
                             & ~state_reg.held);
    end

    case (state_reg.fsm)
      SLP_IDLE: begin
        // R7 R9 start only with system on at a legal stopping point
        if (state_reg.sys_on && stop_point_in && cand_found) begin
          state_next.fsm                  = SLP_FIRST;
          state_next.cur_level            = cand_level;
          state_next.accepted[cand_level] = 1'b0;
          // R11 first location of the level
          state_next.addr                 = slot_addr(cand_level);
          state_next.start_pulse          = 1'b1;
          // R13 executive mode for interrupt instructions
          state_next.exec_mode            = 1'b1;
        end
      end
      SLP_FIRST: begin
        // R14 only the instruction fetched by this sequence counts
        if (instr_done_in) begin
          case (instr_class_in)
            SLP_CLS_NONIO, SLP_CLS_NONIO_JUMP: begin
              // R15 hold the level and resume at the program counter
              state_next.held[state_reg.cur_level] = 1'b1;
              state_next.fsm       = SLP_IDLE;
              state_next.exec_mode = 1'b0;
              // R16 call or jump types leave user mode
              state_next.leave_user =
                user_mode_in && (instr_class_in == SLP_CLS_NONIO_JUMP);
            end
            SLP_CLS_DATA_IO, SLP_CLS_BLOCK_MORE: begin
              // R18 automatic dismissal, nothing held
              state_next.fsm       = SLP_IDLE;
              state_next.exec_mode = 1'b0;
            end
            SLP_CLS_BLOCK_DONE: begin
              // R19 block finished, run the second location
              state_next.fsm         = SLP_SECOND;
              state_next.addr        = slot_addr(state_reg.cur_level)
                                     + 8'h01;
              state_next.start_pulse = 1'b1;
            end
            default: begin
              // R20 condition op in the first location hangs
              state_next.fsm = SLP_HUNG;
            end
          endcase
        end
      end
      SLP_SECOND: begin
        if (instr_done_in) begin
          if (instr_class_in == SLP_CLS_NONIO ||
              instr_class_in == SLP_CLS_NONIO_JUMP) begin
            // R17 a non-jump keeps the level held as a routine
            state_next.held[state_reg.cur_level] = 1'b1;
            state_next.fsm        = SLP_IDLE;
            state_next.exec_mode  = 1'b0;
            state_next.leave_user =
              user_mode_in && (instr_class_in == SLP_CLS_NONIO_JUMP);
          end else begin
            // R20 any IO op in the second location hangs
            state_next.fsm = SLP_HUNG;
          end
        end
      end
      SLP_HUNG: begin
        // only a reset gets the processor out of here
        state_next.hang = 1'b1;
      end
      default: begin
        state_next.fsm = SLP_IDLE;
      end
    endcase

    // R23 dismiss the highest held level; ignored while system off
    if (dismiss_in && state_reg.sys_on && held_found) begin
      state_next.held[held_level] = 1'b0;
    end

    // software commands win over same-cycle hardware updates
    if (cmd.turn_off) begin
      state_next.level_on = state_next.level_on & ~cmd.sel;
    end
    if (cmd.turn_on) begin
      state_next.level_on = state_next.level_on | cmd.sel;
    end
    // forced requests ignore the level switch but are lost on held levels
    if (cmd.force_req) begin
      state_next.accepted = state_next.accepted
                          | (cmd.sel & ~state_next.held);
    end
    if (cmd.deact) begin
      state_next.sys_on = 1'b0;
    end
    if (cmd.act) begin
      state_next.sys_on = 1'b1;
    end
    if (cmd.clear_all) begin
      state_next.sys_on   = 1'b0;
      state_next.level_on = `SLP_LVL_RST;
      state_next.accepted = `SLP_LVL_RST;
      state_next.held     = `SLP_LVL_RST;
    end

    // conditions-in image, level one leftmost in each field
    state_next.status = `SLP_STAT_RST;
    state_next.status[`SLP_CI_SYS_ON] = state_next.sys_on;
    for (int i = 1; i <= 7; i++) begin
      state_next.status[`SLP_CI_HELD_TOP - i] = state_next.held[i];
      state_next.status[`SLP_CI_ON_TOP - i]   = state_next.level_on[i];
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // R24 reset clears the whole interrupt system
      state_reg.fsm         <= SLP_IDLE;
      state_reg.sys_on      <= 1'b0;
      state_reg.level_on    <= `SLP_LVL_RST;
      state_reg.accepted    <= `SLP_LVL_RST;
      state_reg.held        <= `SLP_LVL_RST;
      state_reg.cur_level   <= `SLP_LVLNUM_RST;
      state_reg.addr        <= `SLP_ADDR_RST;
      state_reg.start_pulse <= 1'b0;
      state_reg.exec_mode   <= 1'b0;
      state_reg.leave_user  <= 1'b0;
      state_reg.hang        <= 1'b0;
      state_reg.status      <= `SLP_STAT_RST;
    end else if (clk_en_in) begin
      state_reg <= state_next;
    end
  end

  // R10 the processor keeps its program counter while start is shown
  assign intr_start_out = state_reg.start_pulse;
  assign intr_addr_out  = state_reg.addr;
  assign exec_mode_out  = state_reg.exec_mode;
  assign leave_user_out = state_reg.leave_user;
  assign hang_out       = state_reg.hang;
  assign held_out       = state_reg.held;
  assign status_out     = state_reg.status;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  // R11 first location address
  a_first_slot_addr: assert property (  // R11
    intr_start_out && state_reg.fsm == SLP_FIRST
    |-> intr_addr_out == slot_addr(state_reg.cur_level))
    else $error("first interrupt location address wrong");

  // R7 starts need the system on
  a_start_needs_on: assert property (  // R7
    clk_en_in && state_reg.fsm == SLP_IDLE && !state_reg.sys_on
    |=> !intr_start_out)
    else $error("interrupt started with system off");

  // R13 executive mode during interrupt instructions
  a_exec_mode_held: assert property (  // R13
    state_reg.fsm == SLP_FIRST || state_reg.fsm == SLP_SECOND
    |-> exec_mode_out)
    else $error("interrupt instruction not in executive mode");

  // R15 non-IO instruction holds the level
  a_nonio_holds: assert property (  // R15
    clk_en_in && !cmd.clear_all && state_reg.fsm == SLP_FIRST
    && instr_done_in && instr_class_in == SLP_CLS_NONIO
    |=> held_out[$past(state_reg.cur_level)] && !exec_mode_out)
    else $error("non-IO interrupt instruction did not hold level");

  // R18 data transfer dismisses without holding
  a_data_dismiss: assert property (  // R18
    clk_en_in && state_reg.fsm == SLP_FIRST && instr_done_in
    && instr_class_in == SLP_CLS_DATA_IO
    && !state_reg.held[state_reg.cur_level]
    |=> state_reg.fsm == SLP_IDLE
        && !held_out[$past(state_reg.cur_level)])
    else $error("data transfer did not dismiss");

  // R19 block done goes to the second location
  a_block_second: assert property (  // R19
    clk_en_in && state_reg.fsm == SLP_FIRST && instr_done_in
    && instr_class_in == SLP_CLS_BLOCK_DONE
    |=> intr_start_out
        && intr_addr_out == slot_addr(state_reg.cur_level) + 8'h01)
    else $error("second location not issued");

  // R20 condition op in first location hangs
  a_cond_hang: assert property (  // R20
    clk_en_in && state_reg.fsm == SLP_FIRST && instr_done_in
    && instr_class_in == SLP_CLS_COND_IO
    |=> state_reg.fsm == SLP_HUNG ##1 hang_out[*2])
    else $error("condition op did not hang");

  // R8 no start at or below a held level
  a_no_start_below: assert property (  // R8
    intr_start_out && state_reg.fsm == SLP_FIRST && $past(held_found)
    |-> state_reg.cur_level < $past(held_level))
    else $error("interrupt started below a held level");

  // R16 leave user mode after a call in user mode
  a_leave_user: assert property (  // R16
    clk_en_in && state_reg.fsm == SLP_FIRST && instr_done_in
    && instr_class_in == SLP_CLS_NONIO_JUMP && user_mode_in
    |=> leave_user_out ##1 (!leave_user_out || !$past(clk_en_in)))
    else $error("user mode not left");

  // R24 clear command empties the system
  a_clear_all: assert property (  // R24
    clk_en_in && cmd.clear_all
    |=> !status_out[`SLP_CI_SYS_ON] && held_out == `SLP_LVL_RST)
    else $error("clear command left state behind");

  c_start_first: cover property (intr_start_out
                                 && state_reg.fsm == SLP_FIRST);
  c_second_slot: cover property (intr_start_out
                                 && state_reg.fsm == SLP_SECOND);
  c_dismiss:     cover property (dismiss_in && held_found
                                 && state_reg.sys_on);
  c_hang:        cover property (hang_out);

endmodule
`default_nettype wire

// ---- slp_periph.sv ----
// peripheral controller model driving one level request line
`timescale 1ns/100ps
`default_nettype none
module slp_periph (
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        setup_in,
  input  wire logic [17:0] word_in,
  input  wire logic        event_in,
  input  wire logic        clear_in,
  output logic [7:1]       request_out
);
  logic [2:0] level_reg;
  logic       enable_reg;
  logic       flag_reg;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_reg  <= 3'h0;
      enable_reg <= 1'b0;
      flag_reg   <= 1'b0;
    end else begin
      if (setup_in) begin
        level_reg  <= word_in[2:0];
        enable_reg <= word_in[3];
      end
      if (clear_in)
        flag_reg <= 1'b0;
      else if (event_in)
        flag_reg <= 1'b1;
    end
  end
  // enabled flag only; zero level disconnects; lines or-ed outside
  always_comb begin
    request_out = 7'h00;
    if (flag_reg && enable_reg && level_reg != 3'h0)
      request_out[level_reg] = 1'b1;
  end
endmodule
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the priority interrupt unit
`timescale 1ns/100ps
`default_nettype none
`include "slp_map.svh"
module tb import slp_pkg::*;;
  logic          clock_in, reset_n_in, mem_access_in, stop_point_in;
  logic          cond_out_in, instr_done_in, user_mode_in, dismiss_in;
  logic [8:0]    device_in;
  logic [17:0]   cond_word_in, status_out, dev_word;
  slp_class_type instr_class_in;
  logic [7:1]    request_in, req_a, req_b, held_out;
  logic          intr_start_out, exec_mode_out, leave_user_out, hang_out;
  logic          clk_en_in;
  logic [7:0]    intr_addr_out;
  logic [1:0]    dev_setup, dev_event, dev_clear;
  int            fails, checked, lvl;

  assign request_in = req_a | req_b;
  always #12.5 clock_in = ~clock_in;

  slp_unit #(.SECOND_CPU(1'b0)) i_slp_unit (
    .clock_in       (clock_in),
    .reset_n_in     (reset_n_in),
    .clk_en_in      (clk_en_in),
    .request_in     (request_in),
    .mem_access_in  (mem_access_in),
    .stop_point_in  (stop_point_in),
    .cond_out_in    (cond_out_in),
    .device_in      (device_in),
    .cond_word_in   (cond_word_in),
    .instr_done_in  (instr_done_in),
    .instr_class_in (instr_class_in),
    .user_mode_in   (user_mode_in),
    .dismiss_in     (dismiss_in),
    .intr_start_out (intr_start_out),
    .intr_addr_out  (intr_addr_out),
    .exec_mode_out  (exec_mode_out),
    .leave_user_out (leave_user_out),
    .hang_out       (hang_out),
    .held_out       (held_out),
    .status_out     (status_out)
  );
  slp_periph i_slp_periph_a (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .setup_in(dev_setup[0]), .word_in(dev_word), .event_in(dev_event[0]),
    .clear_in(dev_clear[0]), .request_out(req_a));
  slp_periph i_slp_periph_b (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .setup_in(dev_setup[1]), .word_in(dev_word), .event_in(dev_event[1]),
    .clear_in(dev_clear[1]), .request_out(req_b));

  function automatic logic [17:0] cb(input int k);
    return 18'h00001 << k;
  endfunction
  function automatic logic [6:0] sel(input int n);
    return 7'h40 >> (n - 1);
  endfunction
  function automatic logic [6:0] hv(input int n);
    return 7'h01 << (n - 1);
  endfunction
  function automatic logic [7:0] loc(input int n);
    return `SLP_BASE_FIRST + 8'(2 * n);
  endfunction

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask
  task automatic check(input string what, input logic [17:0] seen,
                       input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cond(input logic [8:0] dev, input logic [17:0] w);
    device_in = dev;
    cond_word_in = w;
    cond_out_in = 1'b1;
    step(1);
    cond_out_in = 1'b0;
    step(1);
  endtask
  // peripheral op: 0 setup, 1 raise flag, 2 clear flag
  task automatic dev(input int k, input int op, input logic [17:0] w);
    dev_word = w;
    case (op)
      0: dev_setup[k] = 1'b1;
      1: dev_event[k] = 1'b1;
      default: dev_clear[k] = 1'b1;
    endcase
    step(1);
    dev_setup = 2'b00;
    dev_event = 2'b00;
    dev_clear = 2'b00;
    step(1);
  endtask
  task automatic accept;
    mem_access_in = 1'b1;
    step(1);
    mem_access_in = 1'b0;
    step(1);
  endtask
  task automatic stop(input logic s);
    stop_point_in = 1'b1;
    step(1);
    check("start", 18'(intr_start_out), 18'(s));
    if (s) begin
      check("addr", 18'(intr_addr_out), 18'(loc(lvl)));
      check("exec", 18'(exec_mode_out), 18'h1);
    end
    stop_point_in = 1'b0;
    step(1);
  endtask
  task automatic done(input slp_class_type c, input logic u,
                      input logic [6:0] h, input logic lv);
    instr_class_in = c;
    user_mode_in = u;
    instr_done_in = 1'b1;
    step(1);
    check("held", 18'(held_out), 18'(h));
    check("leave_user", 18'(leave_user_out), 18'(lv));
    if (c == SLP_CLS_BLOCK_DONE)
      check("second", 18'(intr_addr_out), 18'(loc(lvl) + 8'h01));
    else
      check("exec_off", 18'(exec_mode_out), 18'h0);
    instr_done_in = 1'b0;
    step(1);
  endtask
  task automatic dismiss;
    dismiss_in = 1'b1;
    step(1);
    dismiss_in = 1'b0;
    step(1);
    check("dismissed", 18'(held_out), 18'h0);
  endtask

  initial begin
    #100000;
    fails++;
    print_verdict;
  end

  initial begin
    clock_in = 1'b0;
    clk_en_in = 1'b1;
    reset_n_in = 1'b0;
    {mem_access_in, stop_point_in, cond_out_in, instr_done_in} = 4'h0;
    {user_mode_in, dismiss_in, dev_setup, dev_event, dev_clear} = 8'h00;
    device_in = 9'h000;
    cond_word_in = 18'h00000;
    dev_word = 18'h00000;
    instr_class_in = SLP_CLS_NONIO;
    lvl = $urandom(26);
    step(10);
    reset_n_in = 1'b1;
    step(1);
    check("status", status_out, 18'h00000);
    // foreign device code must be ignored
    cond(`SLP_DEV_CODE ^ 9'(1 + $urandom % 255), cb(`SLP_CO_ACT) | 18'h7F);
    check("status", status_out, 18'h00000);
    cond(`SLP_DEV_CODE, cb(`SLP_CO_ACT) | cb(`SLP_CO_TURN_ON) | 18'h7F);
    check("status", status_out, {3'h0, 7'h00, 1'b1, 7'h7F});
    // frozen unit ignores even a clear command
    clk_en_in = 1'b0;
    cond(`SLP_DEV_CODE, cb(`SLP_CO_CLEAR));
    check("frozen", status_out, {3'h0, 7'h00, 1'b1, 7'h7F});
    clk_en_in = 1'b1;
    $display("test control done");
    for (int n = 1; n <= 7; n++) begin
      lvl = n;
      dev(0, 0, 18'h8 | 18'(n));
      dev(0, 1, 18'h0);
      accept;
      stop(1'b1);
      done(SLP_CLS_NONIO_JUMP, 1'b1, hv(n), 1'b1);
      check("status", status_out, {3'h0, sel(n), 1'b1, 7'h7F});
      dismiss;
      dev(0, 2, 18'h0);
    end
    $display("test levels done");
    // two waiting levels while the system is off
    cond(`SLP_DEV_CODE, cb(`SLP_CO_DEACT));
    dev(0, 0, 18'hD);
    dev(1, 0, 18'hB);
    dev(0, 1, 18'h0);
    dev(1, 1, 18'h0);
    accept;
    stop(1'b0);
    cond(`SLP_DEV_CODE, cb(`SLP_CO_ACT));
    lvl = 3;
    stop(1'b1);
    done(SLP_CLS_NONIO, 1'b1, hv(3), 1'b0);
    dev(1, 2, 18'h0);
    lvl = 5;
    stop(1'b0);
    dismiss;
    stop(1'b1);
    done($urandom % 2 ? SLP_CLS_BLOCK_MORE : SLP_CLS_DATA_IO,
         1'($urandom % 2), 7'h00, 1'b0);
    dev(0, 2, 18'h0);
    $display("test priority done");
    lvl = 1 + $urandom % 7;
    dev(0, 0, 18'h8 | 18'(lvl));
    dev(0, 1, 18'h0);
    accept;
    stop(1'b1);
    done(SLP_CLS_BLOCK_DONE, 1'b0, 7'h00, 1'b0);
    done(SLP_CLS_NONIO_JUMP, 1'b0, hv(lvl), 1'b0);
    dismiss;
    dev(0, 2, 18'h0);
    $display("test block done");
    // level off refuses; forced request still lands
    lvl = 2;
    cond(`SLP_DEV_CODE, cb(`SLP_CO_TURN_OFF) | 18'(sel(2)));
    check("status", status_out, {3'h0, 7'h00, 1'b1, 7'h5F});
    dev(0, 0, 18'hA);
    dev(0, 1, 18'h0);
    accept;
    stop(1'b0);
    cond(`SLP_DEV_CODE, cb(`SLP_CO_FORCE) | 18'(sel(2)));
    stop(1'b1);
    instr_class_in = SLP_CLS_COND_IO;
    instr_done_in = 1'b1;
    step(1);
    instr_done_in = 1'b0;
    step(1);
    check("hang", 18'(hang_out), 18'h1);
    reset_n_in = 1'b0;
    step(1);
    reset_n_in = 1'b1;
    step(1);
    check("status", status_out, 18'h00000);
    check("hang", 18'(hang_out), 18'h0);
    $display("test hang done");
    print_verdict;
  end
endmodule
`default_nettype wire
